// File: bpa_consts.svh
// constants for the bidirectional port block
`ifndef BPA_CONSTS_SVH
`define BPA_CONSTS_SVH
`define BPA_ADDR_PIN_LEVEL   4'h0
`define BPA_ADDR_DIRECTION   4'h1
`define BPA_ADDR_LATCH       4'h2
`define BPA_ADDR_ANALOG_SEL  4'h3
`define BPA_ADDR_COMPARATOR  4'h4
`define BPA_DIR_RESET        8'hff
`define BPA_LATCH_RESET      8'h00
`define BPA_ANALOG_RESET     8'h00
`define BPA_CMP_RESET        8'h00
`define BPA_ANALOG_MASK      8'h2f
`define BPA_OSC_MASK         8'hc0
`define BPA_CMP_MASK         8'h3f
`define BPA_BIT_FOUR         4
`define BPA_ALL_DIGITAL      8'h0f
`endif

// File: bpa_pkg.sv
// types for the bidirectional port block
package bpa_pkg;
  typedef logic [7:0] bpa_byte_t;
  typedef enum logic [1:0] {BPA_OSC_PORT, BPA_OSC_CRYSTAL} bpa_osc_t;
endpackage

// File: bpa_pin_if.sv
// pin-side bundle between the port core and its pad stage
`timescale 1ns/1ps
interface bpa_pin_if;
  logic [7:0] out_val;  // value toward the pads
  logic [7:0] out_en;   // high while a pad is driven
  logic [7:0] in_sync;  // synchronised pad levels
  modport core (output out_val, output out_en, input in_sync);
  modport pad  (input out_val, input out_en, output in_sync);
endinterface

// File: bpa_sync.sv
// two-flop synchroniser and registered pad outputs
`timescale 1ns/1ps
`include "bpa_consts.svh"
module bpa_sync
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // pad side
  input  wire logic [7:0] pad_in,
  output logic      [7:0] pad_out,
  output logic      [7:0] pad_oe,
  // core side
  bpa_pin_if.pad          pins
);
  logic [7:0] meta_r;  // first stage, read only by the second
  logic [7:0] sync_r;  // second stage

  // pad inputs come from outside the clock domain
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= 8'h00;
      sync_r <= 8'h00;
    end
    else
    begin
      meta_r <= pad_in;
      sync_r <= meta_r;
    end
  end

  // registered drive so outputs come straight from flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pad_out <= `BPA_LATCH_RESET;
      pad_oe  <= 8'h00;
    end
    else
    begin
      pad_out <= pins.out_val;
      pad_oe  <= pins.out_en;
    end
  end

  assign pins.in_sync = sync_r;
endmodule // bpa_sync

// File: bpa_mux.sv
// per-pin function mux: port latch or peripheral
`timescale 1ns/1ps
module bpa_mux
(
  // settings
  input  wire logic [7:0] dir,
  input  wire logic [7:0] latch,
  input  wire logic [7:0] periph_own,
  input  wire logic [7:0] periph_val,
  input  wire logic [7:0] periph_oe,
  // pad bundle
  bpa_pin_if.core         pins
);
  // a peripheral owning a pin overrides the port driver
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (periph_own[i])
      begin
        pins.out_val[i] = periph_val[i];
        pins.out_en[i]  = periph_oe[i];
      end
      else
      begin
        pins.out_val[i] = latch[i];
        pins.out_en[i]  = ~dir[i];
      end
    end
  end
endmodule // bpa_mux

// File: bpa_port.sv
// Operation
// - direction, pin level and latch registers
// - eight bits, one per pin, each bidirectional
// - direction one makes pin input, undriven
// - direction zero drives latch onto pin
// - pin read gives pins, write sets latch
// - latch readable and writable for read-modify-write
// - enabled peripheral takes over shared pin
// - bit four shares timer clock, comparator output
// - oscillator-owned bits six, seven read zero
// - analog select picks analog or digital pins
// - reset: analog low pins, bit four digital
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "bpa_consts.svh"
module bpa_port
(
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       NRST,
  // register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // oscillator configuration: high hands bits six, seven to the oscillator
  input  wire logic       OSC_OWNS_HIGH,
  // comparator one output and timer clock tap
  input  wire logic       CMP_ONE_OUT,
  output logic            TIMER_ZERO_CLOCK_IN,
  // pads
  input  wire logic [7:0] PAD_IN,
  output logic      [7:0] PAD_OUT,
  output logic      [7:0] PAD_OE,
  // state views
  output logic      [7:0] ANALOG_PINS
);
  bpa_pkg::bpa_byte_t direction_a_r;       // 1 = input
  bpa_pkg::bpa_byte_t output_latch_a_r;    // driven values
  bpa_pkg::bpa_byte_t analog_select_r;     // 1 = digital pin
  bpa_pkg::bpa_byte_t comparator_control_r; // nonzero = comparators on
  bpa_pkg::bpa_byte_t osc_mask;            // bits hidden by oscillator
  bpa_pkg::bpa_byte_t analog_mask;         // bits in analog use
  bpa_pkg::bpa_byte_t own;                 // peripheral ownership
  bpa_pkg::bpa_byte_t pval;
  bpa_pkg::bpa_byte_t poe;
  bpa_pkg::bpa_byte_t pin_level;           // masked live levels
  bpa_pkg::bpa_byte_t rdata_nxt;
  logic               osc_r;               // oscillator strap sampled every clock
  logic               cmp_on;

  bpa_pin_if pins ();

  // strap sampled by the clock, cleared to zero under reset
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      osc_r <= 1'b0;
    else
      osc_r <= OSC_OWNS_HIGH;
  end

  assign osc_mask    = osc_r ? `BPA_OSC_MASK : 8'h00;
  assign analog_mask = `BPA_ANALOG_MASK & ~analog_select_r;
  assign cmp_on      = |comparator_control_r;

  // comparator one drives bit four when comparators run and direction bit four is zero; oscillator owns high bits
  always_comb
  begin
    own  = osc_mask;
    pval = 8'h00;
    poe  = 8'h00;
    if (cmp_on)
    begin
      own[`BPA_BIT_FOUR]  = 1'b1;
      pval[`BPA_BIT_FOUR] = CMP_ONE_OUT;
      poe[`BPA_BIT_FOUR]  = ~direction_a_r[`BPA_BIT_FOUR];
    end
  end

  // direction register, all inputs at reset
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      direction_a_r <= `BPA_DIR_RESET;
    else if (WR && ADDR == `BPA_ADDR_DIRECTION)
      direction_a_r <= WDATA;
  end

  // latch written through either the pin-level or the latch address
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      output_latch_a_r <= `BPA_LATCH_RESET;
    else if (WR && (ADDR == `BPA_ADDR_PIN_LEVEL || ADDR == `BPA_ADDR_LATCH))
      output_latch_a_r <= WDATA;
  end

  // analog select: reset leaves low pins and bit five analog
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      analog_select_r <= `BPA_ANALOG_RESET;
    else if (WR && ADDR == `BPA_ADDR_ANALOG_SEL)
      analog_select_r <= WDATA;
  end

  // comparator control; zero means off, as software needs for digital inputs
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      comparator_control_r <= `BPA_CMP_RESET;
    else if (WR && ADDR == `BPA_ADDR_COMPARATOR)
      comparator_control_r <= WDATA;
  end

  // pad stage and function mux
  bpa_mux u_mux
  (
    .dir        (direction_a_r),
    .latch      (output_latch_a_r),
    .periph_own (own),
    .periph_val (pval),
    .periph_oe  (poe),
    .pins       (pins.core)
  );

  bpa_sync u_sync
  (
    .clk     (CLOCK),
    .nrst    (NRST),
    .pad_in  (PAD_IN),
    .pad_out (PAD_OUT),
    .pad_oe  (PAD_OE),
    .pins    (pins.pad)
  );

  // analog pins read zero digitally; oscillator bits too
  assign pin_level = pins.in_sync & ~analog_mask & ~osc_mask;

  // read mux; unmapped addresses read zero
  always_comb
  begin
    if (ADDR == `BPA_ADDR_PIN_LEVEL)
      rdata_nxt = pin_level;
    else if (ADDR == `BPA_ADDR_DIRECTION)
      rdata_nxt = direction_a_r & ~osc_mask;
    else if (ADDR == `BPA_ADDR_LATCH)
      rdata_nxt = output_latch_a_r & ~osc_mask;
    else if (ADDR == `BPA_ADDR_ANALOG_SEL)
      rdata_nxt = analog_select_r;
    else if (ADDR == `BPA_ADDR_COMPARATOR)
      rdata_nxt = comparator_control_r;
    else
      rdata_nxt = 8'h00;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= rdata_nxt;
    else
      RDATA <= 8'h00;
  end

  // timer clock tap and analog view, registered
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      TIMER_ZERO_CLOCK_IN <= 1'b0;
      ANALOG_PINS         <= `BPA_ANALOG_MASK;
    end
    else
    begin
      TIMER_ZERO_CLOCK_IN <= pins.in_sync[`BPA_BIT_FOUR];
      ANALOG_PINS         <= analog_mask;
    end
  end

  AST_LATCH_WRITE: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WR && ADDR == `BPA_ADDR_PIN_LEVEL) |=> output_latch_a_r == $past(WDATA))
    else $error("pin-level write did not reach latch");
  AST_DIR_DRIVE: assert property (@(posedge CLOCK) disable iff (!NRST)
    (!osc_r && !cmp_on && !direction_a_r[0]) |=> PAD_OE[0])
    else $error("output pin not driven");
  AST_DIR_INPUT: assert property (@(posedge CLOCK) disable iff (!NRST)
    (!osc_r && direction_a_r[1]) |=> !PAD_OE[1])
    else $error("input pin driven");
  AST_LATCH_READ: assert property (@(posedge CLOCK) disable iff (!NRST)
    (RD && ADDR == `BPA_ADDR_LATCH && !osc_r) |=> RDATA == $past(output_latch_a_r))
    else $error("latch readback wrong");
  AST_OSC_ZERO: assert property (@(posedge CLOCK) disable iff (!NRST)
    (RD && ADDR == `BPA_ADDR_DIRECTION && osc_r) |=> RDATA[7:6] == 2'b00)
    else $error("oscillator bits not zero");
  AST_ANALOG_ZERO: assert property (@(posedge CLOCK) disable iff (!NRST)
    (RD && ADDR == `BPA_ADDR_PIN_LEVEL && !analog_select_r[0]) |=> !RDATA[0])
    else $error("analog pin read nonzero");
  AST_CMP_OWN: assert property (@(posedge CLOCK) disable iff (!NRST)
    (cmp_on && !direction_a_r[4]) |=> PAD_OUT[4] == $past(CMP_ONE_OUT))
    else $error("comparator output not on bit four");
  AST_DIR_WRITE: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WR && ADDR == `BPA_ADDR_DIRECTION) |=> direction_a_r == $past(WDATA))
    else $error("direction write lost");
endmodule // bpa_port

// File: bpa_board.sv
// board model of the circuitry on the port pins
`timescale 1ns/1ps
module bpa_board
(
  // pads from the port
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  // level the board applies to released pins
  input  wire logic [7:0] ext_level,
  // levels seen at the pads
  output logic      [7:0] pad_in
);
  // a driven pad shows the port's value, a released one the board's level
  // the bench changes the board level often, so stale drive never passes
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_level[i];
    end
  end
endmodule // bpa_board

// File: bpa_port_tb.sv
// self-checking bench for the bidirectional port
`timescale 1ns/1ps
`include "bpa_consts.svh"
module bpa_port_tb;
  logic               clk, nrst, wr, rd, osc, cmp, timer;  // strobes and levels
  logic [3:0]         addr;                                // register address
  bpa_pkg::bpa_byte_t wdata, rdata, pad_in, pad_out, pad_oe, analog, ext;
  int                 failures, num_checks;                // tallies

  bpa_port bpa_port_inst (.CLOCK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .OSC_OWNS_HIGH(osc), .CMP_ONE_OUT(cmp), .TIMER_ZERO_CLOCK_IN(timer),
    .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .ANALOG_PINS(analog));
  bpa_board bpa_board_inst (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext), .pad_in(pad_in));

  // free-running clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // verdict and end of run
  task complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // compare one byte result
  task chk(input bpa_pkg::bpa_byte_t got, input bpa_pkg::bpa_byte_t exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle write, strobe dropped on the edge that takes it; the next task's own edge wait keeps strobes apart
  task wreg(input logic [3:0] a, input bpa_pkg::bpa_byte_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read strobe, data taken in the following cycle only
  task rchk(input logic [3:0] a, input bpa_pkg::bpa_byte_t exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask

  // let pad and synchroniser pipelines drain, sample mid-cycle
  task settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // reset state of direction, latch, pin level, unmapped read, pad enables and analog view
  task reset_state;
    rchk(`BPA_ADDR_DIRECTION, 8'hff);
    rchk(`BPA_ADDR_LATCH, 8'h00);
    rchk(`BPA_ADDR_PIN_LEVEL, 8'hd0);
    rchk(4'hf, 8'h00);
    chk(pad_oe, 8'h00);
    chk(analog, 8'h2f);
  endtask

  // digital mode, latch writes, drive and read back the pins
  task drive_out;
    wreg(`BPA_ADDR_ANALOG_SEL, 8'h2f);
    wreg(`BPA_ADDR_COMPARATOR, 8'h00);
    wreg(`BPA_ADDR_PIN_LEVEL, 8'ha5);
    rchk(`BPA_ADDR_LATCH, 8'ha5);
    chk(analog, 8'h00);
    wreg(`BPA_ADDR_DIRECTION, 8'h00);
    settle(4);
    chk(pad_oe, 8'hff);
    chk(pad_out, 8'ha5);
    rchk(`BPA_ADDR_PIN_LEVEL, 8'ha5);
    ext <= 8'h3c;
    wreg(`BPA_ADDR_DIRECTION, 8'hf0);
    settle(5);
    rchk(`BPA_ADDR_PIN_LEVEL, 8'h35);
    chk(pad_oe, 8'h0f);
  endtask

  // oscillator takes the two top pins
  task osc_owned;
    @(posedge clk);
    ext <= 8'hff;
    osc <= 1'b1;
    settle(5);
    rchk(`BPA_ADDR_DIRECTION, 8'h30);
    rchk(`BPA_ADDR_LATCH, 8'h25);
    rchk(`BPA_ADDR_PIN_LEVEL, 8'h35);
    chk(pad_oe & 8'hc0, 8'h00);
    @(posedge clk);
    osc <= 1'b0;
  endtask

  // comparator output and timer clock share bit four
  task comparator_pin;
    @(posedge clk);
    cmp <= 1'b1;
    wreg(`BPA_ADDR_DIRECTION, 8'hef);
    wreg(`BPA_ADDR_LATCH, 8'h00);
    wreg(`BPA_ADDR_COMPARATOR, 8'h01);
    settle(4);
    chk(pad_out & 8'h10, 8'h10);
    chk(pad_oe & 8'h10, 8'h10);
    wreg(`BPA_ADDR_COMPARATOR, 8'h00);
    settle(4);
    chk(pad_out & 8'h10, 8'h00);
    wreg(`BPA_ADDR_DIRECTION, 8'hff);
    ext <= 8'h10;
    settle(5);
    chk({7'h00, timer}, 8'h01);
  endtask

  // main sequence, with a second reset in mid-run
  initial
  begin
    {nrst, wr, rd, osc, cmp} = 5'h00;
    addr  = 4'h0;
    wdata = 8'h00;
    ext   = 8'hff;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    reset_state;
    drive_out;
    osc_owned;
    comparator_pin;
    @(posedge clk);
    nrst <= 1'b0;
    ext  <= 8'hff;
    settle(3);
    chk(pad_oe, 8'h00);
    @(posedge clk);
    nrst <= 1'b1;
    reset_state;
    complete_run;
  end

  // watchdog against a hung run
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    complete_run;
  end
endmodule // bpa_port_tb
